// *** rtl/qusp_pkg.sv ***
// package: constants, states and helpers for the quad uart host serial port
`default_nettype none
package qusp_pkg;
	// register map seen by the host
	localparam logic [7:0] REG_FIFO     = 8'h00;
	localparam logic [7:0] REG_GLOBAL   = 8'h1F;
	localparam logic [7:0] REG_REVISION = 8'h25;
	localparam logic [7:0] REG_LAST     = 8'h25;
	// revision value is arbitrary
	localparam logic [7:0] REV_VALUE    = 8'h5A;
	// global trigger data byte is this prefix plus the trigger number
	localparam logic [3:0] TRIG_PREFIX  = 4'hE;
	// bit counts
	localparam logic [3:0] BYTE_LAST    = 4'h7;
	localparam logic [3:0] ACK_SLOT     = 4'h8;
	localparam logic [3:0] MISO_QUIET   = 4'h4;
	// strap codes and the address field swap
	localparam logic [1:0] STRAP_GND    = 2'h0;
	localparam logic [1:0] STRAP_VL     = 2'h1;
	localparam logic [1:0] STRAP_SCL    = 2'h2;
	localparam logic [1:0] STRAP_SDA    = 2'h3;
	localparam logic [3:0] ADDR_SWAP    = 4'hC;

	typedef enum logic [2:0] {
		I_IDLE = 3'h0,
		I_ADDR = 3'h1,
		I_REG  = 3'h3,
		I_DATA = 3'h2,
		I_TX   = 3'h6,
		I_WAIT = 3'h7
	} qusp_i2c_t;

	// a strap that never differed from a bus line is tied to that line
	function automatic logic [1:0] qusp_strap(input logic mscl,
		input logic msda, input logic lvl);
		if (!mscl)
			return STRAP_SCL;
		if (!msda)
			return STRAP_SDA;
		return lvl ? STRAP_VL : STRAP_GND;
	endfunction : qusp_strap

	// address bits 4:1 from the strap pair; codes 0 and 12 trade places
	function automatic logic [3:0] qusp_field(input logic [3:0] idx);
		if (idx == 4'h0)
			return ADDR_SWAP;
		if (idx == ADDR_SWAP)
			return 4'h0;
		return idx;
	endfunction : qusp_field
endpackage : qusp_pkg
`default_nettype wire

// *** rtl/qusp_host_port.sv ***
// quad uart host serial port: spi or i2c target front end
// What this block does
// RULE1 - spi command byte: write/read bit, two uart bits, five address bits
// RULE2 - uart select bits decode binary, 00 uart0 through 11 uart3
// RULE3 - spi master uses mode 0: clock idles low, rising edge samples
// RULE4 - data output stays undriven for the whole of a write cycle
// RULE5 - read cycle: output undriven for first 4 command clocks, then driven
// RULE6 - burst from nonzero address increments address after each byte
// RULE7 - burst at address zero streams fifo, address stays put
// RULE8 - select held low through a burst; high select ends it
// RULE9 - every spi byte is exactly 8 serial clocks
// RULE10 - four uart interrupts merge onto one active-low output
// RULE11 - fast read reports interrupt sources in 8 clocks, uart bits ignored; here the byte follows the 8-clock command, 16 clocks in all
// RULE12 - fast read byte: bit n set when uart n interrupts, rest zero
// RULE13 - i2c target works with bus clock up to 1 MHz
// RULE14 - 7-bit address, two straps each tied four ways, 16 devices
// RULE15 - four addresses, one per uart; grounded straps give D8 B8 58 38
// RULE16 - address byte lsb is direction: 1 read, 0 write
// RULE17 - one bit per clock; data moves only while clock low
// RULE18 - write: start, address, ack, register, ack, data, ack, stop
// RULE19 - register address acked only when valid, else nack
// RULE20 - burst write: any number of data bytes, each acked
// RULE21 - read: register write, repeated start, read address, data, nack
// RULE22 - burst read continues while master acknowledges each byte
// RULE23 - ack pulls data low through ninth clock high; nack leaves it
// RULE24 - i2c bursts stream at address zero, increment elsewhere
// RULE25 - global trigger command starts transmit on matching uarts
`default_nettype none
module qusp_host_port (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// host pins
	input  wire logic       spi_mode,
	input  wire logic       sclk_scl,
	input  wire logic       select_or_strap_low,
	input  wire logic       host_in_or_strap_high,
	input  wire logic       sda_i,
	output var  logic       miso_o,
	output var  logic       miso_oe,
	output var  logic       sda_o,
	output var  logic       sda_oe,
	output var  logic       irq_n,
	// uart bank side
	input  wire logic [3:0] uart_irq,
	input  wire logic [7:0] reg_rdata,
	output var  logic       reg_wr,
	output var  logic       reg_rd,
	output var  logic [1:0] reg_uart,
	output var  logic [7:0] reg_addr,
	output var  logic [7:0] reg_wdata,
	output var  logic       trig,
	output var  logic [3:0] trig_num
);
	import qusp_pkg::*;

	typedef struct packed {
		logic [1:0] sc, cs, mi, sd, md;
		logic       scp;
		logic       sdp;
		qusp_i2c_t  ist;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic [7:0] tsh;
		logic [7:0] addr;
		logic [7:0] raddr;
		logic [7:0] wdata;
		logic [1:0] uart;
		logic [1:0] ruart;
		logic [1:0] msc;
		logic [1:0] msd;
		logic       sdat;
		logic       rdc;
		logic       fast;
		logic       ld;
		logic       rv;
		logic       inack;
		logic       mack;
		logic       rw;
		logic       miso;
		logic       misooe;
		logic       sdaoe;
		logic       sdao;
		logic       irqn;
		logic       wr;
		logic       rd;
		logic       trig;
		logic [3:0] tnum;
	} qusp_state_t;

	qusp_state_t q;
	qusp_state_t n;
	logic        sr, sf, i2c_start, i2c_stop, acc, accw, ack;
	logic [7:0]  aa;
	logic [7:0]  ab;
	logic [1:0]  au;
	logic [3:0]  sidx;

	// edges seen through the synchronisers, three cycles late at most;
	// at 1 MHz a half period is 50 cycles, so no margin problem
	assign sr        = q.sc[1] & ~q.scp; // RULE3 RULE13
	assign sf        = ~q.sc[1] & q.scp;
	assign i2c_start = q.sc[1] & q.scp & q.sdp & ~q.sd[1]; // RULE17
	assign i2c_stop  = q.sc[1] & q.scp & ~q.sdp & q.sd[1];
	assign ab        = {q.sh[6:0], q.md[1] ? q.mi[1] : q.sd[1]};
	assign sidx      = {qusp_strap(q.msc[1], q.msd[1], q.mi[1]),
		qusp_strap(q.msc[0], q.msd[0], q.cs[1])}; // RULE14

	always_comb begin
		n = q;
		acc = 1'b0;
		accw = 1'b0;
		ack = 1'b0;
		aa = q.addr;
		au = q.uart;
		n.sc = {q.sc[0], sclk_scl};
		n.cs = {q.cs[0], select_or_strap_low};
		n.mi = {q.mi[0], host_in_or_strap_high};
		n.sd = {q.sd[0], sda_i};
		n.md = {q.md[0], spi_mode};
		n.scp = q.sc[1];
		n.sdp = q.sd[1];
		n.wr = 1'b0;
		n.rd = 1'b0;
		n.trig = 1'b0;
		n.ld = 1'b0;
		n.sdao = 1'b0;
		n.irqn = ~|uart_irq; // RULE10
		if (q.ld)
			n.tsh = q.rv ? REV_VALUE : reg_rdata;
		if (q.md[1]) begin
			n.sdaoe = 1'b0;
			n.ist = I_IDLE;
			if (q.cs[1]) begin
				// select high ends any burst
				n.cnt = 4'h0; // RULE8
				n.sdat = 1'b0;
				n.rdc = 1'b0;
				n.fast = 1'b0;
				n.misooe = 1'b0;
				n.miso = 1'b0;
			end else begin
				if (sr) begin
					n.sh = ab;
					n.cnt = q.cnt + 4'h1;
					if (q.cnt == 4'h0 && !q.sdat)
						n.rdc = ~q.mi[1]; // RULE1
					if (q.cnt == BYTE_LAST) begin
						n.cnt = 4'h0; // RULE9
						n.sdat = 1'b1;
						if (!q.sdat) begin
							au = ab[6:5]; // RULE2
							aa = {3'h0, ab[4:0]}; // RULE1
							n.uart = au;
							n.addr = aa;
							// uart bits do not matter here
							n.fast = q.rdc && aa == REG_GLOBAL; // RULE11
							if (n.fast)
								n.tsh = {4'h0, uart_irq}; // RULE12
							else
								acc = q.rdc;
						end else if (q.fast) begin
							n.tsh = {4'h0, uart_irq}; // RULE12
						end else begin
							acc = 1'b1;
							accw = ~q.rdc;
						end
					end
				end
				if (sf) begin
					if (q.rdc && (q.sdat || q.cnt >= MISO_QUIET))
						n.misooe = 1'b1; // RULE4 RULE5
					if (q.rdc && q.sdat) begin
						n.miso = q.tsh[7];
						n.tsh = {q.tsh[6:0], 1'b0};
					end
				end
			end
		end else begin
			n.misooe = 1'b0;
			n.sdat = 1'b0;
			n.rdc = 1'b0;
			n.fast = 1'b0;
			// a strap that ever differs from a bus line is not tied to it
			n.msc = q.msc | ({q.mi[1], q.cs[1]} ^ {2{q.sc[1]}});
			n.msd = q.msd | ({q.mi[1], q.cs[1]} ^ {2{q.sd[1]}});
			if (i2c_start) begin
				n.ist = I_ADDR;
				n.cnt = 4'h0;
				n.inack = 1'b0;
				n.sdaoe = 1'b0;
			end else if (i2c_stop) begin
				n.ist = I_IDLE;
				n.inack = 1'b0;
				n.sdaoe = 1'b0;
				n.msc = 2'h0;
				n.msd = 2'h0;
			end else if (q.ist != I_IDLE && q.ist != I_WAIT) begin
				if (sr) begin
					if (!q.inack) begin
						n.sh = ab; // RULE17
						n.cnt = q.cnt + 4'h1;
					end else if (q.ist == I_TX) begin
						n.mack = ~q.sd[1]; // RULE22
						acc = ~q.sd[1];
					end
				end
				if (sf) begin
					if (q.cnt == ACK_SLOT && !q.inack) begin
						n.inack = 1'b1;
						case (q.ist)
							I_ADDR: begin
								ack = q.sh[6] == ~q.sh[5] &&
									q.sh[4:1] == qusp_field(sidx); // RULE15
								if (ack) begin
									au = {~q.sh[7], q.sh[5]};
									n.uart = au;
									n.rw = q.sh[0]; // RULE16
									acc = q.sh[0]; // RULE21
								end else begin
									n.ist = I_WAIT;
								end
							end
							I_REG: begin
								ack = q.sh <= REG_LAST; // RULE19
								n.addr = q.sh;
								if (!ack)
									n.ist = I_WAIT;
							end
							I_DATA: begin
								ack = 1'b1; // RULE18 RULE20
								acc = 1'b1;
								accw = 1'b1;
							end
							default: ack = 1'b0;
						endcase
						n.sdaoe = ack; // RULE23
					end else if (q.inack) begin
						n.inack = 1'b0;
						n.cnt = 4'h0;
						n.sdaoe = 1'b0;
						case (q.ist)
							I_ADDR: n.ist = q.rw ? I_TX : I_REG;
							I_REG: n.ist = I_DATA;
							I_TX: n.ist = q.mack ? I_TX : I_WAIT; // RULE22
							default: n.ist = q.ist;
						endcase
						if ((q.ist == I_ADDR && q.rw) ||
							(q.ist == I_TX && q.mack)) begin
							n.sdaoe = ~q.tsh[7];
							n.tsh = {q.tsh[6:0], 1'b0};
						end
					end else if (q.ist == I_TX) begin
						n.sdaoe = ~q.tsh[7];
						n.tsh = {q.tsh[6:0], 1'b0};
					end
				end
			end
		end
		if (acc) begin
			n.raddr = aa;
			n.ruart = au;
			// the fifo port keeps its address, every other one steps on
			n.addr = (aa == REG_FIFO) ? aa : aa + 8'h01; // RULE6 RULE7 RULE24
			if (accw) begin
				n.wr = 1'b1;
				n.wdata = q.md[1] ? ab : q.sh;
				if (aa == REG_GLOBAL && n.wdata[7:4] == TRIG_PREFIX) begin
					n.trig = 1'b1; // RULE25
					n.tnum = n.wdata[3:0];
				end
			end else begin
				// the revision register is answered here, not by a bank
				n.rv = aa == REG_REVISION;
				n.rd = aa != REG_REVISION;
				n.ld = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q <= '0;
			q.cs <= 2'h3;
			q.sd <= 2'h3;
			q.sdp <= 1'b1;
			q.irqn <= 1'b1;
		end else begin
			q <= n;
		end
	end

	assign miso_o    = q.miso;
	assign miso_oe   = q.misooe;
	assign sda_o     = q.sdao;
	assign sda_oe    = q.sdaoe;
	assign irq_n     = q.irqn;
	assign reg_wr    = q.wr;
	assign reg_rd    = q.rd;
	assign reg_uart  = q.ruart;
	assign reg_addr  = q.raddr;
	assign reg_wdata = q.wdata;
	assign trig      = q.trig;
	assign trig_num  = q.tnum;

	AST_WR_QUIET: assert property (@(posedge clk) disable iff (rst) // RULE4
		q.md[1] && !q.rdc |-> !miso_oe)
		else $error("data output driven outside a read");
	AST_CMD_QUIET: assert property (@(posedge clk) disable iff (rst) // RULE5
		q.md[1] && !q.sdat && q.cnt < MISO_QUIET |-> !miso_oe)
		else $error("data output driven in first command clocks");
	AST_BYTE_EIGHT: assert property (@(posedge clk) disable iff (rst) // RULE9
		$rose(q.sdat) |-> $past(q.cnt) == BYTE_LAST)
		else $error("command byte not eight clocks long");
	AST_STEP: assert property (@(posedge clk) disable iff (rst) // RULE6
		reg_wr && reg_addr != REG_FIFO |-> q.addr == reg_addr + 8'h01)
		else $error("burst address did not step by one");
	AST_STREAM: assert property (@(posedge clk) disable iff (rst) // RULE7
		(reg_wr || reg_rd) && reg_addr == REG_FIFO |-> q.addr == REG_FIFO)
		else $error("fifo burst address moved");
	AST_FAST: assert property (@(posedge clk) disable iff (rst) // RULE12
		q.md[1] && $rose(q.fast) |-> q.tsh == {4'h0, $past(uart_irq)})
		else $error("fast read byte does not match interrupts");
	AST_IRQ: assert property (@(posedge clk) disable iff (rst) // RULE10
		1'b1 |=> irq_n == ~|$past(uart_irq))
		else $error("shared interrupt output wrong");
	AST_NAK_BAD: assert property (@(posedge clk) disable iff (rst) // RULE19
		!q.md[1] && $rose(q.inack) && $past(q.ist) == I_REG
		|-> sda_oe == ($past(q.sh) <= REG_LAST))
		else $error("register address ack does not match validity");
	AST_ACK_EDGE: assert property (@(posedge clk) disable iff (rst) // RULE23
		!q.md[1] && $changed(sda_oe)
		|-> $past(sf) || $past(i2c_start) || $past(i2c_stop))
		else $error("data line moved away from a clock fall");
	AST_CS_END: assert property (@(posedge clk) disable iff (rst) // RULE8
		q.md[1] && q.cs[1] |=> !miso_oe && !q.sdat)
		else $error("burst not ended by select high");
endmodule : qusp_host_port
`default_nettype wire

// *** testbench/qusp_host_model.sv ***
// host master model for the spi and i2c pins of the port
`default_nettype none
module qusp_host_model (
	// clock and strap
	input  wire logic clk,
	input  wire logic spi,
	// port pins
	output var  logic sclk_scl,
	output var  logic select_or_strap_low,
	output var  logic host_in_or_strap_high,
	output var  logic sda_i,
	input  wire logic miso_o,
	input  wire logic miso_oe,
	input  wire logic sda_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       cs_n = 1'b1;
	logic       dl = 1'b1;
	logic       last = 1'b0;
	logic       oe_seen;
	logic       oe_early;
	int         nbit;
	logic [7:0] txb [4];
	logic [7:0] rxb [4];
	// a released miso shows the inverse of its last level, not a stale copy
	always @(posedge clk) if (miso_oe) last <= miso_o;
	// i2c straps grounded; sda pulled up, the device only pulls low
	assign select_or_strap_low = spi & cs_n;
	assign host_in_or_strap_high = spi & dl;
	assign sda_i = spi | (dl & ~sda_oe);
	initial sclk_scl = 1'b0;
	task automatic wt(input int n);
		repeat (n) @(negedge clk);
	endtask : wt
	// data moves mid-low, sampled at the rise
	task automatic bit_x(input logic o, output logic i);
		sclk_scl = 1'b0;
		wt(2);
		dl = o;
		wt(2);
		sclk_scl = 1'b1;
		i = spi ? (miso_oe ? miso_o : ~last) : sda_i;
		oe_seen |= miso_oe;
		oe_early |= miso_oe & (nbit < 4);
		nbit++;
		wt(4);
	endtask : bit_x
	task automatic xbyte(input logic [7:0] o, output logic [7:0] i);
		for (int k = 7; k >= 0; k--) begin
			bit_x(o[k], i[k]);
		end
	endtask : xbyte
	task automatic spi_frame(input logic [7:0] cmd, input int n);
		logic [7:0] d;
		cs_n = 1'b0;
		oe_seen = 1'b0;
		oe_early = 1'b0;
		nbit = 0;
		wt(4);
		xbyte(cmd, d);
		for (int b = 0; b < n; b++) begin
			xbyte(txb[b], rxb[b]);
		end
		sclk_scl = 1'b0;
		wt(4);
		cs_n = 1'b1;
		wt(8);
	endtask : spi_frame
	// also serves as repeated start
	task automatic i2c_start();
		sclk_scl = 1'b0;
		wt(2);
		dl = 1'b1;
		wt(2);
		sclk_scl = 1'b1;
		wt(4);
		dl = 1'b0;
		wt(4);
	endtask : i2c_start
	task automatic i2c_stop();
		sclk_scl = 1'b0;
		wt(2);
		dl = 1'b0;
		wt(2);
		sclk_scl = 1'b1;
		wt(4);
		dl = 1'b1;
		wt(4);
	endtask : i2c_stop
	task automatic i2c_wr(input logic [7:0] b, output logic ack_n);
		logic [7:0] d;
		xbyte(b, d);
		bit_x(1'b1, ack_n);
	endtask : i2c_wr
	task automatic i2c_rd(input logic ack_n, output logic [7:0] d);
		logic x;
		xbyte(8'hFF, d);
		bit_x(ack_n, x);
	endtask : i2c_rd
endmodule : qusp_host_model
`default_nettype wire

// *** testbench/tb_qusp_host_port.sv ***
// self-checking bench for the quad uart host serial port
`default_nettype none
module tb_qusp_host_port import qusp_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        spi_mode = 1'b1;
	logic        sclk_scl, cs, mo, sda_i, miso_o, miso_oe, sda_o, sda_oe;
	logic        irq_n, reg_wr, reg_rd, trig, ack_n;
	logic [1:0]  reg_uart;
	logic [3:0]  uart_irq = 4'h0;
	logic [3:0]  trig_num;
	logic [7:0]  reg_rdata;
	logic [7:0]  reg_addr, reg_wdata, rb;
	logic [7:0]  wb [4] = '{8'hD8, 8'h03, 8'h77, 8'h88};
	logic [17:0] wr_q [$];
	logic [9:0]  rd_q [$];
	int          failures = 0;
	int          num_checks = 0;
	int          trigs = 0;
	qusp_host_port dut (.clk(clk), .rst(rst), .spi_mode(spi_mode),
		.sclk_scl(sclk_scl), .select_or_strap_low(cs),
		.host_in_or_strap_high(mo), .sda_i(sda_i), .miso_o(miso_o),
		.miso_oe(miso_oe), .sda_o(sda_o), .sda_oe(sda_oe), .irq_n(irq_n),
		.uart_irq(uart_irq), .reg_rdata(reg_rdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_uart(reg_uart), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .trig(trig), .trig_num(trig_num));
	qusp_host_model host (.clk(clk), .spi(spi_mode), .sclk_scl(sclk_scl),
		.select_or_strap_low(cs), .host_in_or_strap_high(mo),
		.sda_i(sda_i), .miso_o(miso_o), .miso_oe(miso_oe), .sda_oe(sda_oe));
	initial forever #5 clk = ~clk;
	// bank side: the port latches read data at the end of the pulse cycle,
	// so the bank answers combinationally from the held address
	assign reg_rdata = reg_addr ^ 8'h3C;
	always @(posedge clk) begin
		if (reg_wr === 1'b1) wr_q.push_back({reg_uart, reg_addr, reg_wdata});
		if (reg_rd === 1'b1) rd_q.push_back({reg_uart, reg_addr});
		if (trig === 1'b1) trigs++;
	end
	task automatic chk(input string nm, input logic [17:0] e, g);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
		end
	endtask : chk
	function automatic logic [17:0] pw();
		return wr_q.size() ? wr_q.pop_front() : 'x;
	endfunction : pw
	function automatic logic [9:0] pr();
		return rd_q.size() ? rd_q.pop_front() : 'x;
	endfunction : pr
	task automatic wrap_up();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : wrap_up
	// idle i2c lines high in reset so the straps never match a bus line
	task automatic reset_dut(input logic m);
		@(negedge clk);
		rst = 1'b1;
		spi_mode = m;
		if (!m) host.i2c_stop();
		repeat (12) @(negedge clk);
		chk("rst_out", 7'h01, {miso_oe, miso_o, sda_oe, sda_o, reg_wr,
			reg_rd, irq_n});
		rst = 1'b0;
		repeat (6) @(negedge clk);
		wr_q.delete();
		rd_q.delete();
	endtask : reset_dut
	task automatic i2c_open(input logic [7:0] a, r);
		host.i2c_start();
		host.i2c_wr(a, ack_n);
		chk("a_ack", 1'b0, ack_n);
		host.i2c_wr(r, ack_n);
		chk("r_ack", 1'b0, ack_n);
		host.i2c_start();
		host.i2c_wr(a | 8'h01, ack_n);
		chk("ra_ack", 1'b0, ack_n);
	endtask : i2c_open
	initial begin
		#200000;
		failures++;
		wrap_up();
	end
	initial begin
		reset_dut(1'b1);
		host.txb = '{8'h11, 8'h22, 8'h33, 8'h00};
		host.spi_frame({1'b1, 2'h2, 5'h02}, 3);
		chk("wr_a", {2'h2, 8'h02, 8'h11}, pw());
		chk("wr_b", {2'h2, 8'h03, 8'h22}, pw());
		chk("wr_c", {2'h2, 8'h04, 8'h33}, pw());
		chk("wr_oe", 1'b0, host.oe_seen);
		for (int u = 0; u < 4; u++) begin
			host.spi_frame({1'b1, u[1:0], 5'h00}, 2);
			chk("fifo_a", {u[1:0], 8'h00, 8'h11}, pw());
			chk("fifo_b", {u[1:0], 8'h00, 8'h22}, pw());
		end
		host.txb[0] = 8'hE8;
		host.spi_frame({1'b1, 2'h0, 5'h1F}, 1);
		chk("trig", 5'h18, {trigs == 1, trig_num});
		host.spi_frame({1'b0, 2'h3, 5'h05}, 2);
		chk("rd_a", 8'h05 ^ 8'h3C, host.rxb[0]);
		chk("rd_b", 8'h06 ^ 8'h3C, host.rxb[1]);
		chk("rd_addr", {2'h3, 8'h05}, pr());
		chk("rd_oe", 2'b10, {host.oe_seen, host.oe_early});
		uart_irq = 4'hA;
		rd_q.delete();
		host.spi_frame({1'b0, 2'h1, 5'h1F}, 1);
		chk("fast", 8'h0A, host.rxb[0]);
		chk("fast_rd", 1'b0, rd_q.size() != 0);
		chk("irq", 1'b0, irq_n);
		uart_irq = 4'h0;
		repeat (3) @(negedge clk);
		chk("irq_off", 1'b1, irq_n);
		reset_dut(1'b0);
		host.i2c_start();
		host.i2c_wr(8'hD0, ack_n);
		chk("no_match", 1'b1, ack_n);
		host.i2c_stop();
		host.i2c_start();
		foreach (wb[k]) begin
			host.i2c_wr(wb[k], ack_n);
			chk("w_ack", 1'b0, ack_n);
		end
		host.i2c_stop();
		chk("i2c_wa", {2'h0, 8'h03, 8'h77}, pw());
		chk("i2c_wb", {2'h0, 8'h04, 8'h88}, pw());
		host.i2c_start();
		host.i2c_wr(8'hB8, ack_n);
		chk("u1_ack", 1'b0, ack_n);
		host.i2c_wr(8'h30, ack_n);
		chk("bad_reg", 1'b1, ack_n);
		host.i2c_stop();
		i2c_open(8'hB8, 8'h25);
		host.i2c_rd(1'b1, rb);
		host.i2c_stop();
		chk("rev", REV_VALUE, rb);
		rd_q.delete();
		i2c_open(8'h38, 8'h10);
		host.i2c_rd(1'b0, rb);
		chk("br_a", 8'h10 ^ 8'h3C, rb);
		host.i2c_rd(1'b1, rb);
		host.i2c_stop();
		chk("br_b", 8'h11 ^ 8'h3C, rb);
		chk("br_addr", {2'h3, 8'h10}, pr());
		wrap_up();
	end
endmodule : tb_qusp_host_port
`default_nettype wire
